// File: hdl/sbh_store_exec.v
// sbh_store_exec.v: decode and execute the short store forms (byte, half, word by register)
// assumes a register file with two-cycle-free combinational read ports and a memory
// port that holds a write until it answers with done or error
//
// How it works
// - word store by register writes all 32 source bits at base plus offset register, four bytes wide.
// - byte store immediate is found by bits 15..11, offset 10..6, base 5..3, source 2..0, offset zero-extended.
// - byte store immediate writes source bits 7..0 at base plus offset, one byte, no base update.
// - byte store by register is found by bits 15..9, offset register 8..6, base 5..3, source 2..0.
// - byte store by register adds the unshifted offset register to the base and writes source bits 7..0.
// - half store immediate is found by bits 15..11, its 5-bit field shifted left one and zero-extended.
// - half store immediate writes source bits 15..0 at base plus offset, two bytes, no base update.
// - half store by register is found by bits 15..9 with fields placed as in the byte register form.
// - half store by register adds the unshifted offset register to the base and writes source bits 15..0.
// - the base register is never written back by any of these stores.
// - immediate forms always add the offset and use the sum as the access address.
`timescale 1ns/10ps
`include "sbh_defines.vh"

module sbh_store_exec #(
  parameter DATA_W = 32,
  parameter REG_AW = 3
) (
  // clock and reset
  input  wire              clock,
  input  wire              rst_n,
  // instruction issue
  input  wire              instr_valid,
  input  wire [15:0]       instr_word,
  output wire              instr_ready,
  output wire              instr_decoded,
  // register file read ports
  output wire [REG_AW-1:0] base_reg_field,
  output wire [REG_AW-1:0] offset_reg_field,
  output wire [REG_AW-1:0] source_reg_field,
  input  wire [DATA_W-1:0] base_value,
  input  wire [DATA_W-1:0] offset_value,
  input  wire [DATA_W-1:0] source_value,
  // sized memory write
  output wire              mem_wr_valid,
  output reg  [DATA_W-1:0] mem_wr_addr,
  output reg  [DATA_W-1:0] mem_wr_data,
  output reg  [2:0]        mem_wr_size,
  input  wire              mem_wr_done,
  input  wire              mem_wr_error,
  // completion
  output reg               instr_done,
  output reg               hard_fault_exception
);

  ////////////////////////////////////////////////////////////////////////////
  // state and kind codes

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_WRITE = 2'h1;

  localparam [2:0] KIND_NONE     = 3'h0;
  localparam [2:0] KIND_BYTE_IMM = 3'h1;
  localparam [2:0] KIND_HALF_IMM = 3'h2;
  localparam [2:0] KIND_BYTE_REG = 3'h3;
  localparam [2:0] KIND_HALF_REG = 3'h4;
  localparam [2:0] KIND_WORD_REG = 3'h5;

  // byte lanes of the write data
  localparam LANES = DATA_W / 8;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // word immediate forms match none of these and fall through to none
  function [2:0] sbh_kind;
    input [15:0] w;
    begin
      if (w[`SBH_OP5_HI:`SBH_OP5_LO] == `SBH_OP5_BYTE_IMM)
        sbh_kind = KIND_BYTE_IMM;
      else if (w[`SBH_OP5_HI:`SBH_OP5_LO] == `SBH_OP5_HALF_IMM)
        sbh_kind = KIND_HALF_IMM;
      else if (w[`SBH_OP5_HI:`SBH_OP7_LO] == `SBH_OP7_BYTE_REG)
        sbh_kind = KIND_BYTE_REG;
      else if (w[`SBH_OP5_HI:`SBH_OP7_LO] == `SBH_OP7_HALF_REG)
        sbh_kind = KIND_HALF_REG;
      else if (w[`SBH_OP5_HI:`SBH_OP7_LO] == `SBH_OP7_WORD_REG)
        sbh_kind = KIND_WORD_REG;
      else
        sbh_kind = KIND_NONE;
    end
  endfunction

  // bytes moved by one access of a given kind
  function [2:0] sbh_size_of;
    input [2:0] k;
    begin
      case (k)
        KIND_BYTE_IMM: sbh_size_of = `SBH_SIZE_BYTE;
        KIND_BYTE_REG: sbh_size_of = `SBH_SIZE_BYTE;
        KIND_HALF_IMM: sbh_size_of = `SBH_SIZE_HALF;
        KIND_HALF_REG: sbh_size_of = `SBH_SIZE_HALF;
        KIND_WORD_REG: sbh_size_of = `SBH_SIZE_WORD;
        default:       sbh_size_of = `SBH_SIZE_NONE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode of the offered word

  reg  [1:0]        state_reg;
  reg  [1:0]        state_next;
  wire [2:0]        kind_now;
  wire [4:0]        imm_offset_field;
  wire              is_store;
  wire              take;

  assign kind_now         = sbh_kind(instr_word);
  assign imm_offset_field = instr_word[`SBH_IMM_HI:`SBH_IMM_LO];
  assign is_store         = (kind_now != KIND_NONE);
  // an undecoded word is neither taken nor refused; it simply waits
  assign take             = (state_reg == ST_IDLE) && instr_valid && is_store;

  assign instr_ready      = (state_reg == ST_IDLE);
  assign instr_decoded    = instr_valid && is_store;
  assign base_reg_field   = instr_word[`SBH_BASE_HI:`SBH_BASE_LO];
  assign offset_reg_field = instr_word[`SBH_OFFS_HI:`SBH_OFFS_LO];
  assign source_reg_field = instr_word[`SBH_SRC_HI:`SBH_SRC_LO];

  ////////////////////////////////////////////////////////////////////////////
  // address

  reg  [DATA_W-1:0] offset_now;
  wire [DATA_W-1:0] addr_now;

  // immediates are zero-extended, register offsets go in unshifted
  always @* begin
    case (kind_now)
      KIND_BYTE_IMM: begin
        offset_now = {{(DATA_W-5){1'h0}}, imm_offset_field};
      end
      KIND_HALF_IMM: begin
        offset_now = {{(DATA_W-6){1'h0}}, imm_offset_field, 1'h0};
      end
      default: begin
        offset_now = offset_value;
      end
    endcase
  end

  // always an add, never a subtract; the sum wraps like the core adder
  assign addr_now = base_value + offset_now;

  ////////////////////////////////////////////////////////////////////////////
  // data and size

  wire [2:0]        size_now;
  wire [DATA_W-1:0] data_now;

  assign size_now = sbh_size_of(kind_now);

  // lanes above the access size carry zeros so a bus monitor sees clean data
  // limitation: DATA_W must be a whole number of bytes
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
      wire lane_on;
      assign lane_on = (lane < size_now);
      assign data_now[lane*8 +: 8] = lane_on ? source_value[lane*8 +: 8] : 8'h00;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  // one store at a time; the next may be taken on the edge the done pulse falls
  always @* begin
    case (state_reg)
      ST_IDLE: begin
        state_next = take ? ST_WRITE : ST_IDLE;
      end
      ST_WRITE: begin
        // error wins over done; either ends the access
        state_next = (mem_wr_done || mem_wr_error) ? ST_IDLE : ST_WRITE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mem_wr_valid = (state_reg == ST_WRITE);

  ////////////////////////////////////////////////////////////////////////////
  // write request, held until the memory answers

  // operands are sampled only at the take edge, so later changes on the
  // read ports cannot disturb a pending write
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr_addr <= {DATA_W{`SBH_RST_BIT}};
      mem_wr_data <= {DATA_W{`SBH_RST_BIT}};
      mem_wr_size <= `SBH_SIZE_NONE;
    end else if (take) begin
      // no port toward the register file writes, so the base stays put
      mem_wr_addr <= addr_now;
      mem_wr_data <= data_now;
      mem_wr_size <= size_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion pulses

  wire write_error;
  wire write_done;

  // an error abandons the store: no done pulse, only the fault
  assign write_error = mem_wr_valid && mem_wr_error;
  assign write_done  = mem_wr_valid && mem_wr_done && !mem_wr_error;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      instr_done           <= `SBH_RST_BIT;
      hard_fault_exception <= `SBH_RST_BIT;
    end else begin
      instr_done           <= write_done;
      hard_fault_exception <= write_error;
    end
  end

endmodule // sbh_store_exec

// File: hdl/sbh_defines.vh
// sbh_defines.vh: opcodes, field positions, sizes and reset values of the small store unit
// assumes a 16-bit instruction word and a 32-bit register file outside the block
`ifndef SBH_DEFINES_VH
`define SBH_DEFINES_VH

// opcodes
`define SBH_OP5_BYTE_IMM 5'h0e
`define SBH_OP5_HALF_IMM 5'h10
`define SBH_OP7_WORD_REG 7'h28
`define SBH_OP7_HALF_REG 7'h29
`define SBH_OP7_BYTE_REG 7'h2a

// field positions
`define SBH_OP5_HI  15
`define SBH_OP5_LO  11
`define SBH_OP7_LO  9
`define SBH_IMM_HI  10
`define SBH_IMM_LO  6
`define SBH_OFFS_HI 8
`define SBH_OFFS_LO 6
`define SBH_BASE_HI 5
`define SBH_BASE_LO 3
`define SBH_SRC_HI  2
`define SBH_SRC_LO  0

// access sizes, in bytes; none is also the reset value
`define SBH_SIZE_NONE 3'h0
`define SBH_SIZE_BYTE 3'h1
`define SBH_SIZE_HALF 3'h2
`define SBH_SIZE_WORD 3'h4

// reset value of every registered output bit
`define SBH_RST_BIT 1'h0

`endif

// File: verif/sbh_store_exec_properties.sv
// checker for sbh_store_exec, bound to its ports
// assumes register values answer the fields combinationally
`timescale 1ns/10ps
module sbh_store_checker (
  // watched ports
  input wire        clock,
  input wire        rst_n,
  input wire        instr_valid,
  input wire [15:0] instr_word,
  input wire        instr_ready,
  input wire        instr_decoded,
  input wire [31:0] base_value,
  input wire [31:0] offset_value,
  input wire [31:0] source_value,
  input wire        mem_wr_valid,
  input wire [31:0] mem_wr_addr,
  input wire [31:0] mem_wr_data,
  input wire [2:0]  mem_wr_size,
  input wire        mem_wr_done,
  input wire        mem_wr_error,
  input wire        instr_done,
  input wire        hard_fault_exception
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire       tk = instr_ready && instr_valid && instr_decoded;
  wire [4:0] o5 = instr_word[15:11];
  wire [6:0] o7 = instr_word[15:9];
  reg [31:0] b_q, o_q, s_q;
  reg [4:0]  i_q;
  // operands as seen at the take edge
  always @(posedge clock) begin
    if (tk) begin
      b_q <= base_value;
      o_q <= offset_value;
      s_q <= source_value;
      i_q <= instr_word[10:6];
    end
  end
  a_decode_match: assert property (instr_decoded == (instr_valid && (o5 == 5'h0e || o5 == 5'h10
    || o7 == 7'h28 || o7 == 7'h29 || o7 == 7'h2a))) else $error("decode flag wrong");
  a_byte_imm: assert property (tk && o5 == 5'h0e |=> mem_wr_size == 3'h1 && mem_wr_addr == b_q + {27'h0, i_q}
    && mem_wr_data == {24'h0, s_q[7:0]}) else $error("byte imm write wrong");
  a_half_imm: assert property (tk && o5 == 5'h10 |=> mem_wr_size == 3'h2 && mem_wr_addr == b_q + {26'h0, i_q, 1'b0}
    && mem_wr_data == {16'h0, s_q[15:0]}) else $error("half imm write wrong");
  a_byte_reg: assert property (tk && o7 == 7'h2a |=> mem_wr_size == 3'h1 && mem_wr_addr == b_q + o_q
    && mem_wr_data == {24'h0, s_q[7:0]}) else $error("byte reg write wrong");
  a_half_reg: assert property (tk && o7 == 7'h29 |=> mem_wr_size == 3'h2 && mem_wr_addr == b_q + o_q
    && mem_wr_data == {16'h0, s_q[15:0]}) else $error("half reg write wrong");
  a_word_reg: assert property (tk && o7 == 7'h28 |=> mem_wr_size == 3'h4 && mem_wr_addr == b_q + o_q
    && mem_wr_data == s_q) else $error("word reg write wrong");
  a_req_hold: assert property (mem_wr_valid && !mem_wr_done && !mem_wr_error |=> mem_wr_valid
    && $stable(mem_wr_addr) && $stable(mem_wr_data)) else $error("write changed while pending");
  a_err_fault: assert property (mem_wr_valid && mem_wr_error |=> hard_fault_exception && !instr_done
    ##1 !hard_fault_exception) else $error("fault pulse wrong");
  cover property (tk);
  cover property (mem_wr_valid && mem_wr_error);
  cover property (instr_done);
endmodule // sbh_store_checker
bind sbh_store_exec sbh_store_checker i_chk (
  .clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ready(instr_ready), .instr_decoded(instr_decoded), .base_value(base_value),
  .offset_value(offset_value), .source_value(source_value), .mem_wr_valid(mem_wr_valid),
  .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_size(mem_wr_size),
  .mem_wr_done(mem_wr_done), .mem_wr_error(mem_wr_error), .instr_done(instr_done),
  .hard_fault_exception(hard_fault_exception));

// File: verif/sbh_mem_model.sv
// memory side: answers a pending write after lat cycles
// err turns the answer into an error instead of done
`timescale 1ns/10ps
module sbh_mem_model (
  // clock, reset and request
  input  wire       clock,
  input  wire       rst_n,
  input  wire       mem_wr_valid,
  // answer control from the bench
  input  wire [1:0] lat,
  input  wire       err,
  output wire       mem_wr_done,
  output wire       mem_wr_error
);
  reg [1:0] cnt_reg;
  wire      hit = mem_wr_valid && cnt_reg == lat;
  assign mem_wr_done  = hit && !err;
  assign mem_wr_error = hit && err;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) cnt_reg <= 2'h0;
    else cnt_reg <= (mem_wr_valid && !hit) ? cnt_reg + 2'h1 : 2'h0;
  end
endmodule // sbh_mem_model

// File: verif/tb_top.sv
// bench for sbh_store_exec with a small register file
// memory answers come from sbh_mem_model
`timescale 1ns/10ps
module tb_top;
  reg         clock = 0, rst_n = 0, instr_valid = 0, err = 0;
  reg  [15:0] instr_word = 16'h0;
  reg  [1:0]  lat = 2'h0;
  reg  [31:0] rf [0:7];
  wire [2:0]  bf, of, sf, mem_wr_size;
  wire [31:0] mem_wr_addr, mem_wr_data;
  wire        instr_ready, mem_wr_valid, mem_wr_done, mem_wr_error, instr_done, hard_fault_exception;
  integer     num_errors = 0, cmp_count = 0, i;
  always #5 clock = ~clock;
  sbh_store_exec i_dut (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .instr_decoded(), .base_reg_field(bf), .offset_reg_field(of),
    .source_reg_field(sf), .base_value(rf[bf]), .offset_value(rf[of]), .source_value(rf[sf]),
    .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_size(mem_wr_size), .mem_wr_done(mem_wr_done), .mem_wr_error(mem_wr_error),
    .instr_done(instr_done), .hard_fault_exception(hard_fault_exception));
  sbh_mem_model i_mem (.clock(clock), .rst_n(rst_n), .mem_wr_valid(mem_wr_valid), .lat(lat), .err(err),
    .mem_wr_done(mem_wr_done), .mem_wr_error(mem_wr_error));
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one store: offer, check the write, wait for the pulse
  task go(input [15:0] w, input [1:0] l, input e, input [31:0] a, input [31:0] d, input [2:0] s);
    integer n;
    @(posedge clock); instr_word <= w; instr_valid <= 1; lat <= l; err <= e;
    @(posedge clock); instr_valid <= 0;
    #1 chk("addr", mem_wr_addr, a);
    chk("data", mem_wr_data, d);
    chk("size", {29'h0, mem_wr_size}, {29'h0, s});
    n = 0;
    while ((instr_done | hard_fault_exception) !== 1'b1 && n < 9) begin @(posedge clock); #1 n++; end
    chk("done", {31'h0, instr_done}, {31'h0, !e});
    chk("fault", {31'h0, hard_fault_exception}, {31'h0, e});
  endtask
  task t_imm;
    go({5'h0e, 5'h1f, 3'h1, 3'h2}, 2'h0, 1'h0, rf[1] + 32'h1f, {24'h0, rf[2][7:0]}, 3'h1);
    go({5'h10, 5'h1f, 3'h4, 3'h5}, 2'h2, 1'h0, rf[4] + 32'h3e, {16'h0, rf[5][15:0]}, 3'h2);
    go({5'h10, 5'h00, 3'h3, 3'h1}, 2'h1, 1'h0, rf[3], {16'h0, rf[1][15:0]}, 3'h2);
    $display("immediate test done");
  endtask
  task t_reg;
    go({7'h2a, 3'h6, 3'h1, 3'h2}, 2'h0, 1'h0, rf[1] + rf[6], {24'h0, rf[2][7:0]}, 3'h1);
    go({7'h29, 3'h4, 3'h7, 3'h3}, 2'h1, 1'h0, rf[7] + rf[4], {16'h0, rf[3][15:0]}, 3'h2);
    go({7'h28, 3'h2, 3'h6, 3'h5}, 2'h0, 1'h0, rf[6] + rf[2], rf[5], 3'h4);
    $display("register test done");
  endtask
  task t_fault;
    go({7'h29, 3'h1, 3'h2, 3'h3}, 2'h2, 1'h1, rf[2] + rf[1], {16'h0, rf[3][15:0]}, 3'h2);
    go({5'h0e, 5'h05, 3'h0, 3'h7}, 2'h0, 1'h0, rf[0] + 32'h5, {24'h0, rf[7][7:0]}, 3'h1);
    // a word immediate store is not ours and must be ignored
    @(posedge clock); instr_word <= 16'h6000; instr_valid <= 1;
    repeat (3) @(posedge clock);
    #1 chk("idle", {31'h0, mem_wr_valid}, 32'h0);
    @(posedge clock); instr_valid <= 0;
    $display("fault test done");
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    for (i = 0; i < 8; i++) rf[i] = 32'h9e3779b9 * (i + 3);
    rf[4] = 32'hfffffff0;
    repeat (16) @(posedge clock);
    rst_n <= 1;
    t_imm;
    t_reg;
    t_fault;
    report_and_stop;
  end
  // about 50 cycles expected, so 2000 is ample
  initial begin
    #20000;
    num_errors++;
    report_and_stop;
  end
endmodule // tb_top
